/* bench/dbrs_bank_refresh_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module dbrs_chk
  import dbrs_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 srst,
  input wire logic [CMD_W-1:0]     cmd,
  input wire logic [BANK_W-1:0]    bank_sel,
  input wire logic                 refresh_fire_q,
  input wire logic [BANK_W-1:0]    refresh_bank_q,
  input wire logic [NUM_BANKS-1:0] bank_busy_q,
  input wire logic [NUM_BANKS-1:0] timing_violation_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_ok; cmd == CMD_REFRESH && !bank_busy_q[bank_sel]; endsequence
  property p_go; s_ok |=> refresh_fire_q && refresh_bank_q == $past(bank_sel); endproperty
  a_go: assert property (p_go) else $error("refresh lost");
  property p_cmd; refresh_fire_q |-> $past(cmd) == CMD_REFRESH; endproperty
  a_cmd: assert property (p_cmd) else $error("stray refresh");
  property p_b2b; s_ok ##1 s_ok |=> refresh_fire_q && $past(refresh_fire_q); endproperty
  a_b2b: assert property (p_b2b) else $error("pair lost");
  property p_oth; cmd != CMD_NOP && !bank_busy_q[bank_sel] |=> bank_busy_q[$past(bank_sel)]; endproperty
  a_oth: assert property (p_oth) else $error("idle bank refused");
  property p_vio; cmd != CMD_NOP && bank_busy_q[bank_sel] |=> timing_violation_q[$past(bank_sel)] && !refresh_fire_q; endproperty
  a_vio: assert property (p_vio) else $error("busy bank not refused");
  cover property (s_ok ##1 s_ok);
  cover property (refresh_fire_q ##3 refresh_fire_q);
  cover property (refresh_fire_q && refresh_bank_q == 3'h7);
endmodule
bind dbrs_bank_refresh dbrs_chk u_chk (.clk, .srst, .cmd, .bank_sel, .refresh_fire_q, .refresh_bank_q, .bank_busy_q,
  .timing_violation_q);
`default_nettype wire

/* bench/dbrs_bank_refresh_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module dbrs_bank_refresh_tb_top;
  import dbrs_pkg::*;
  logic              clk = 1'b0, srst = 1'b1, fire;
  logic [CMD_W-1:0]  cmd;
  logic [BANK_W-1:0] bank_sel, bank;
  logic [ROW_W-1:0]  row, rows [NUM_BANKS] = '{default: ROW_ZERO};
  logic [16:0]       notes [$];
  logic [NUM_BANKS-1:0] vio;
  logic [DONE_W-1:0] done;
  int                fail_count = 0, num_checks = 0, s;
  always #50 clk = ~clk;
  dbrs_host host (.clk, .cmd, .bank_sel);
  dbrs_bank_refresh dut (.clk, .srst, .cmd, .bank_sel, .row_cycle_time(TRC_ZERO), .refresh_fire_q(fire),
    .refresh_bank_q(bank), .refresh_row_q(row), .bank_busy_q(), .timing_violation_q(vio), .refresh_count_q(done));
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp) $display("unexpected at %0t: %h not %h", $time, got, exp);
    fail_count += int'(got !== exp);
  endtask
  task automatic go(input logic [BANK_W-1:0] b);
    notes.push_back({b, rows[b]});
    rows[b] += ROW_ONE;
    host.issue(CMD_REFRESH, b, 1'b0);
  endtask
  task automatic summarize(input int bad);
    fail_count += bad;
    if (fail_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) #1 if (fire === 1'b1) chk({bank, row}, notes.size() ? notes.pop_front() : '1);
  initial #100000 summarize(1);
  // Three bursts of one refresh per bank in a random odd-stride order, then one bank twice at minimum spacing.
  initial
  begin
    s = $urandom(32'h2E86);
    repeat (2) @(negedge clk);
    srst <= 1'b0;
    host.issue(CMD_NOP, 3'h5, 1'b1);
    for (int k = 0; k < 26; k++) go(k < 24 ? 3'(s + k * (2 * (s >> k / 8) + 1)) : 3'h2);
    host.issue(CMD_REFRESH, 3'h2, 1'b1);
    host.issue(CMD_NOP, 3'h2, 1'b1);
    chk(17'(notes.size()), 17'h0);
    chk(17'(vio), 17'h00004);
    chk(17'(done), 17'h0001A);
    summarize(0);
  end
endmodule
`default_nettype wire

/* bench/dbrs_host.sv */
`timescale 1ns/1ns
`default_nettype none
module dbrs_host
  import dbrs_pkg::*;
(
  input  wire logic              clk,
  output var  logic [CMD_W-1:0]  cmd,
  output var  logic [BANK_W-1:0] bank_sel
);
  int cyc = 0;
  int last [NUM_BANKS] = '{default: -9};
  initial {cmd, bank_sel} = '0;
  always @(posedge clk) cyc <= cyc + 1;
  // Waits with NOPs until the bank's row cycle has run, unless told to break the spacing.
  task automatic issue(input logic [CMD_W-1:0] c, input logic [BANK_W-1:0] b, input bit rude);
    while (!rude && cyc + 1 - last[b] < 3)
    begin
      {cmd, bank_sel} <= {CMD_NOP, ~bank_sel};
      @(negedge clk);
    end
    {cmd, bank_sel} <= {c, b};
    if (!rude) last[b] = cyc + 1;
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

/* verilog/dbrs_bank_refresh.sv */
// What this block and its host must do
// (R1) Refresh exactly one row in selected bank.
// (R2) Row comes from internal counter, address ignored.
// (R3) Host drives valid bank select with refresh.
// (R4) Other banks accept commands during a refresh.
// (R5) Host waits row cycle before same bank.
// (R6) Host refreshes all rows every 32 ms.
// (R7) Host issues 128K refreshes per period.
// (R8) Host may burst eight refreshes every 1.95 us.
// (R9) Refresh captured whole on one crossing.
// (R10) Next crossing may refresh a different bank.
// (R11) Host picks banks whose row cycle elapsed.
// (R12) Row cycle three cycles, four write-to-read; block applies the same row cycle after writes.
// (R13) Row cycle holds for any following command.
// (R14) Host schedules refreshes into idle slots.
`timescale 1ns/1ns
`default_nettype none
module dbrs_bank_refresh
  import dbrs_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic [CMD_W-1:0]       cmd,
  input  wire logic [BANK_W-1:0]      bank_sel,
  input  wire logic [TRC_W-1:0]       row_cycle_time,
  output logic                        refresh_fire_q,
  output logic      [BANK_W-1:0]      refresh_bank_q,
  output logic      [ROW_W-1:0]       refresh_row_q,
  output logic      [NUM_BANKS-1:0]   bank_busy_q,
  output logic      [NUM_BANKS-1:0]   timing_violation_q,
  output logic      [DONE_W-1:0]      refresh_count_q
);

  logic [ROW_W-1:0]     row_ctr_q [NUM_BANKS];
  logic [TRC_W-1:0]     busy_cnt_q [NUM_BANKS];
  logic                 is_refresh;
  logic                 is_access;
  logic [TRC_W-1:0]     trc_load;
  logic                 load_busy;
  logic [NUM_BANKS-1:0] hit_idle;
  logic [NUM_BANKS-1:0] hit_busy;
  logic [NUM_BANKS-1:0] busy_d;
  logic [NUM_BANKS-1:0] violation_d;
  logic                 fire_d;
  logic [ROW_W-1:0]     row_sel;

  // Zero on the row-cycle input selects the default spacing.
  function automatic logic [TRC_W-1:0] trc_sel(input logic [TRC_W-1:0] t);
    trc_sel = (t == TRC_ZERO) ? ROW_CYCLE_TIME_DEF : t;
  endfunction

  function automatic logic bank_match(input logic [BANK_W-1:0] sel, input int b);
    bank_match = (sel == BANK_W'(b));
  endfunction

  function automatic logic cnt_idle(input logic [TRC_W-1:0] cnt);
    cnt_idle = (cnt == TRC_ZERO);
  endfunction

  // The whole refresh command, bank included, is taken on one edge.
  assign is_refresh = (cmd == CMD_REFRESH); // R9
  assign is_access  = (cmd != CMD_NOP);
  assign trc_load   = trc_sel(row_cycle_time);
  assign load_busy  = (trc_load > TRC_ONE);
  assign fire_d     = is_refresh && cnt_idle(busy_cnt_q[bank_sel]); // R1
  assign row_sel    = row_ctr_q[bank_sel];

  // Sorts the command into a hit on an idle bank or on a busy bank.
  always_comb
  begin
    hit_idle    = '0;
    hit_busy    = '0;
    busy_d      = '0;
    violation_d = '0;
    for (int b = 0; b < NUM_BANKS; b++)
    begin
      if (is_access && bank_match(bank_sel, b))
      begin
        hit_idle[b] = cnt_idle(busy_cnt_q[b]); // R4 R10
        hit_busy[b] = !cnt_idle(busy_cnt_q[b]); // R5 R13
      end
      busy_d[b]      = (hit_idle[b] && load_busy) || (busy_cnt_q[b] > TRC_ONE);
      violation_d[b] = timing_violation_q[b] || hit_busy[b];
    end
  end

  // Each bank runs its own row-cycle countdown so banks overlap freely.
  always_ff @(posedge clk)
  begin
    for (int b = 0; b < NUM_BANKS; b++)
    begin
      if (srst)
      begin
        busy_cnt_q[b] <= TRC_ZERO;
      end
      else if (hit_idle[b])
      begin
        busy_cnt_q[b] <= trc_load - TRC_ONE; // R4 R10
      end
      else if (!cnt_idle(busy_cnt_q[b]))
      begin
        busy_cnt_q[b] <= busy_cnt_q[b] - TRC_ONE;
      end
    end
  end

  // The busy flag mirrors a nonzero countdown in the same cycle.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bank_busy_q <= '0;
    end
    else
    begin
      bank_busy_q <= busy_d;
    end
  end

  // A command into a busy bank is dropped and flagged until reset.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      timing_violation_q <= '0;
    end
    else
    begin
      timing_violation_q <= violation_d; // R5 R13
    end
  end

  // Rows are advanced per bank by the internal counter, one per refresh.
  always_ff @(posedge clk)
  begin
    for (int b = 0; b < NUM_BANKS; b++)
    begin
      if (srst)
      begin
        row_ctr_q[b] <= ROW_ZERO;
      end
      else if (is_refresh && hit_idle[b])
      begin
        row_ctr_q[b] <= row_ctr_q[b] + ROW_ONE; // R1 R2
      end
    end
  end

  // The pulse marks the single cycle after an accepted refresh.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      refresh_fire_q <= 1'b0;
    end
    else
    begin
      refresh_fire_q <= fire_d; // R1
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      refresh_bank_q <= '0;
    end
    else if (fire_d)
    begin
      refresh_bank_q <= bank_sel; // R3
    end
  end

  // The row reported is the one the counter held before it advanced.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      refresh_row_q <= ROW_ZERO;
    end
    else if (fire_d)
    begin
      refresh_row_q <= row_sel; // R2
    end
  end

  // The running total wraps silently when it overflows.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      refresh_count_q <= DONE_ZERO;
    end
    else if (fire_d)
    begin
      refresh_count_q <= refresh_count_q + DONE_ONE;
    end
  end

endmodule
`default_nettype wire

/* verilog/dbrs_pkg.sv */
package dbrs_pkg;

  localparam int unsigned NUM_BANKS     = 8;
  localparam int unsigned BANK_W        = 3;
  localparam int unsigned ROW_W         = 14;
  localparam int unsigned TRC_W         = 4;
  localparam int unsigned DONE_W        = 18;
  localparam int unsigned CMD_W         = 2;

  localparam logic [CMD_W-1:0] CMD_NOP     = 2'h0;
  localparam logic [CMD_W-1:0] CMD_READ    = 2'h1;
  localparam logic [CMD_W-1:0] CMD_WRITE   = 2'h2;
  localparam logic [CMD_W-1:0] CMD_REFRESH = 2'h3;

  localparam logic [TRC_W-1:0] ROW_CYCLE_TIME_DEF = 4'h3;
  localparam logic [TRC_W-1:0] TRC_ZERO           = 4'h0;
  localparam logic [TRC_W-1:0] TRC_ONE            = 4'h1;
  localparam logic [ROW_W-1:0] ROW_ZERO           = 14'h0000;
  localparam logic [ROW_W-1:0] ROW_ONE            = 14'h0001;
  localparam logic [DONE_W-1:0] DONE_ZERO         = 18'h00000;
  localparam logic [DONE_W-1:0] DONE_ONE          = 18'h00001;

  localparam real REFRESH_PERIOD_MS = 32.0;
  localparam int unsigned REFRESH_CMDS_PER_PERIOD = 131072;

endpackage
